// File: adsc_params.svh
// Constants for the converter sequence control block
`ifndef ADSC_PARAMS_SVH
`define ADSC_PARAMS_SVH
`define ADSC_OFF_CTRL1 4'h0
`define ADSC_OFF_CTRL2 4'h1
`define ADSC_OFF_CTRL3 4'h2
`define ADSC_OFF_INSEL 4'h3
`define ADSC_OFF_PINCFG 4'h4
`define ADSC_OFF_SCANSEL 4'h5
`define ADSC_OFF_BUFBASE 5'h10
`define ADSC_CTRL1_ON 15
`define ADSC_CTRL1_TRIGGER_SOURCE_SELECT_LO 5
`define ADSC_CTRL1_SIMSEL 3
`define ADSC_CTRL1_AUTO_SAMPLE_ENABLE 2
`define ADSC_CTRL1_SAMPLE 1
`define ADSC_CTRL1_DONE 0
`define ADSC_CTRL2_VREF_LO 13
`define ADSC_CTRL2_SCANEN 10
`define ADSC_CTRL2_CHCNT_LO 8
`define ADSC_CTRL2_HALF 7
`define ADSC_CTRL2_SPLIT 1
`define ADSC_CTRL2_ALT 0
`define ADSC_CTRL2_SPI_LO 2
`define ADSC_CTRL3_AUTO_SAMPLE_CLOCKS_LO 8
`define ADSC_CONV_TADS 5'd12
`define ADSC_TRIG_SW 3'h0
`define ADSC_TRIG_AUTO 3'h7
`define ADSC_MAX_KSPS 500
`endif

// File: adsc_pkg.sv
// Types for the converter sequence control block
package adsc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SAMPLE = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_NEXT = 4'b1000
    } adsc_state_e;
    typedef struct packed {
        logic [3:0] posInput;
        logic negInput;
    } adsc_mux_s;
    typedef struct packed {
        logic start;
        logic [1:0] channel;
        adsc_mux_s sel;
        logic [1:0] vref;
    } adsc_conv_req_s;
endpackage

// File: adsc_result_ram.sv
// Sixteen-word result memory, written only by the sequencer
`timescale 1ns/100ps
module adsc_result_ram
    import adsc_pkg::*;
(
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [3:0] wrAddr,
    input wire logic [9:0] wrData,
    input wire logic [3:0] rdAddr,
    output logic [9:0] rdData
);
    logic [9:0] mem [0:15];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// File: adsc_clk_div.sv
// Conversion clock period tick generator
`timescale 1ns/100ps
module adsc_clk_div
    import adsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [5:0] divider,
    output logic tick
);
    // One half instruction cycle per clk, so a period is divider+1 clocks
    logic [5:0] count;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 6'h00;
        end else if (!run || count == divider) begin
            count <= 6'h00;
        end else begin
            count <= count + 6'h01;
        end
    end

    assign tick = run && (count == divider);
endmodule

// File: adsc_seq_ctrl.sv
// Converter sequence control: registers, sequencer, multiplexer steering
`timescale 1ns/100ps
`include "adsc_params.svh"
module adsc_seq_ctrl
    import adsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    input wire logic [5:0] extTrig,
    input wire logic [9:0] convResult,
    output adsc_conv_req_s convReq,
    output logic [3:0] holdSample,
    output logic [15:0] pinAnalog,
    output logic conversionIrqFlag
);
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [15:0] ctrl3;
    logic [15:0] inputSelect;
    logic [15:0] scanSelect;
    adsc_state_e state;
    logic tadTick;
    logic [4:0] tadCount;
    logic [1:0] chIdx;
    logic [3:0] seqCount;
    logic [3:0] wrPtr;
    logic upperHalf;
    logic useSetB;
    logic [3:0] scanPos;
    logic ramWr;
    logic [9:0] ramRdData;
    logic rdPending;
    logic rdFromBuf;
    logic [15:0] regHold;
    logic sampleClr;
    logic convOn;
    logic [2:0] trigSel;
    logic [1:0] numCh;
    logic seqEnd;
    logic groupEnd;
    logic trigHit;
    logic [3:0] scanInput;
    logic [1:0] reqCh;

    function automatic logic [1:0] last_channel(input logic [1:0] sel);
        unique case (sel)
            2'h0: last_channel = 2'h0;
            2'h1: last_channel = 2'h1;
            default: last_channel = 2'h3;
        endcase
    endfunction

    // Next selected scan input at or above a position, wrapping to the lowest
    function automatic logic [3:0] next_scan(input logic [15:0] mask, input logic [3:0] from);
        logic [3:0] pick;
        logic found;
        pick = from;
        found = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (!found && i >= from && mask[i[3:0]] && i < 16) begin
                pick = i[3:0];
                found = 1'b1;
            end
        end
        for (int i = 0; i < 16; i++) begin
            if (!found && mask[15 - i]) begin
                pick = 4'(15 - i);
            end
        end
        next_scan = pick;
    endfunction

    assign convOn = ctrl1[`ADSC_CTRL1_ON];
    assign trigSel = ctrl1[`ADSC_CTRL1_TRIGGER_SOURCE_SELECT_LO +: 3];
    assign numCh = ctrl2[`ADSC_CTRL2_CHCNT_LO +: 2];
    logic [15:0] pinCfg;
    assign pinAnalog = pinCfg;
    assign scanInput = next_scan(scanSelect, scanPos);
    assign reqCh = state == ST_NEXT ? chIdx + 2'h1 : chIdx;
    assign sampleClr = regWr && regAddr == {1'b0, `ADSC_OFF_CTRL1} && !regWrData[`ADSC_CTRL1_SAMPLE];
    // Tied to the buffer write so an aborted conversion never ends a sequence
    assign seqEnd = ramWr && chIdx == last_channel(numCh);
    assign groupEnd = seqEnd && seqCount == ctrl2[`ADSC_CTRL2_SPI_LO +: 4];
    assign ramWr = state == ST_CONVERT && tadTick && tadCount == `ADSC_CONV_TADS - 5'd1 && convOn;

    // Trigger: software clear, automatic count, or an external source
    always_comb begin
        unique case (trigSel)
            `ADSC_TRIG_SW: trigHit = sampleClr;
            `ADSC_TRIG_AUTO: trigHit = tadTick && tadCount + 5'd1 >= ctrl3[`ADSC_CTRL3_AUTO_SAMPLE_CLOCKS_LO +: 5]
                && ctrl3[`ADSC_CTRL3_AUTO_SAMPLE_CLOCKS_LO +: 5] != 5'h00;
            default: trigHit = extTrig[trigSel - 3'h1];
        endcase
    end

    adsc_clk_div uDiv (
        .clk(clk),
        .rst(rst),
        .run(convOn),
        .divider(ctrl3[5:0]),
        .tick(tadTick)
    );

    adsc_result_ram uRam (
        .clk(clk),
        .wrEn(ramWr),
        .wrAddr(wrPtr),
        .wrData(convResult),
        .rdAddr(regAddr[3:0]),
        .rdData(ramRdData)
    );

    // Register writes; buffer space ignores writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl1 <= 16'h0000;
            ctrl2 <= 16'h0000;
            ctrl3 <= 16'h0000;
            inputSelect <= 16'h0000;
            pinCfg <= 16'h0000;
            scanSelect <= 16'h0000;
        end else begin
            if (regWr) begin
                unique case (regAddr)
                    {1'b0, `ADSC_OFF_CTRL1}: ctrl1 <= {regWrData[15:1], ctrl1[0] & regWrData[0]};
                    {1'b0, `ADSC_OFF_CTRL2}: ctrl2 <= {regWrData[15:8], ctrl2[7], regWrData[6:0]};
                    {1'b0, `ADSC_OFF_CTRL3}: ctrl3 <= regWrData;
                    {1'b0, `ADSC_OFF_INSEL}: inputSelect <= regWrData;
                    {1'b0, `ADSC_OFF_PINCFG}: pinCfg <= regWrData;
                    {1'b0, `ADSC_OFF_SCANSEL}: scanSelect <= regWrData;
                    default: ;
                endcase
            end
            if (groupEnd) begin
                ctrl1[`ADSC_CTRL1_DONE] <= 1'b1;
                ctrl2[`ADSC_CTRL2_HALF] <= upperHalf ^ ctrl2[`ADSC_CTRL2_SPLIT];
            end
            if (state == ST_SAMPLE && trigHit && trigSel != `ADSC_TRIG_SW) begin
                ctrl1[`ADSC_CTRL1_SAMPLE] <= 1'b0;
            end
            if (seqEnd && ctrl1[`ADSC_CTRL1_AUTO_SAMPLE_ENABLE] && convOn) begin
                ctrl1[`ADSC_CTRL1_SAMPLE] <= 1'b1;
            end
        end
    end

    // Interrupt flag: set wins over a software clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conversionIrqFlag <= 1'b0;
        end else if (groupEnd) begin
            conversionIrqFlag <= 1'b1;
        end else if (regWr && regAddr == {1'b0, `ADSC_OFF_CTRL2} && regWrData[15]) begin
            conversionIrqFlag <= 1'b0;
        end
    end

    // Sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            tadCount <= 5'h00;
            chIdx <= 2'h0;
        end else if (!convOn) begin
            state <= ST_IDLE;
            tadCount <= 5'h00;
            chIdx <= 2'h0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    tadCount <= 5'h00;
                    if (ctrl1[`ADSC_CTRL1_SAMPLE]) begin
                        state <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (tadTick) begin
                        tadCount <= tadCount + 5'h01;
                    end
                    if (trigHit) begin
                        state <= ST_CONVERT;
                        tadCount <= 5'h00;
                    end
                end
                ST_CONVERT: begin
                    if (tadTick) begin
                        tadCount <= tadCount + 5'h01;
                    end
                    if (tadTick && tadCount == `ADSC_CONV_TADS - 5'd1) begin
                        tadCount <= 5'h00;
                        state <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (chIdx == last_channel(numCh)) begin
                        chIdx <= 2'h0;
                        state <= ST_IDLE;
                    end else begin
                        chIdx <= chIdx + 2'h1;
                        state <= ctrl1[`ADSC_CTRL1_SIMSEL] ? ST_CONVERT : ST_SAMPLE;
                    end
                end
            endcase
        end
    end

    // Pointer, split halves, alternation and scan position
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr <= 4'h0;
            upperHalf <= 1'b0;
            seqCount <= 4'h0;
            useSetB <= 1'b0;
            scanPos <= 4'h0;
        end else if (!convOn) begin
            // Turning off restarts the buffer from its first word
            wrPtr <= 4'h0;
            upperHalf <= 1'b0;
            seqCount <= 4'h0;
            useSetB <= 1'b0;
            scanPos <= 4'h0;
        end else if (ramWr) begin
            if (groupEnd) begin
                upperHalf <= ctrl2[`ADSC_CTRL2_SPLIT] & ~upperHalf;
                wrPtr <= {ctrl2[`ADSC_CTRL2_SPLIT] & ~upperHalf, 3'h0};
                seqCount <= 4'h0;
                useSetB <= ctrl2[`ADSC_CTRL2_ALT] & ~useSetB;
                scanPos <= 4'h0;
            end else begin
                wrPtr <= ctrl2[`ADSC_CTRL2_SPLIT] ? {upperHalf, wrPtr[2:0] + 3'h1} : wrPtr + 4'h1;
                if (seqEnd) begin
                    seqCount <= seqCount + 4'h1;
                    useSetB <= ctrl2[`ADSC_CTRL2_ALT] & ~useSetB;
                end
                if (chIdx == 2'h0) begin
                    scanPos <= scanInput + 4'h1;
                end
            end
        end
    end

    // Converter core request: input for the active channel and reference choice
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            convReq <= '0;
            holdSample <= 4'h0;
        end else begin
            // Simultaneous mode asks for each further channel as it leaves the step state
            convReq.start <= convOn && (state == ST_SAMPLE && trigHit
                || state == ST_NEXT && ctrl1[`ADSC_CTRL1_SIMSEL] && chIdx != last_channel(numCh));
            convReq.channel <= reqCh;
            convReq.vref <= ctrl2[`ADSC_CTRL2_VREF_LO +: 2];
            if (reqCh == 2'h0 && ctrl2[`ADSC_CTRL2_SCANEN] && !useSetB) begin
                convReq.sel.posInput <= scanInput;
            end else begin
                convReq.sel.posInput <= useSetB ? inputSelect[11:8] : inputSelect[3:0];
            end
            convReq.sel.negInput <= useSetB ? inputSelect[12] : inputSelect[4];
            for (int c = 0; c < 4; c++) begin
                holdSample[c] <= state == ST_SAMPLE && c <= last_channel(numCh)
                    && (ctrl1[`ADSC_CTRL1_SIMSEL] || chIdx == 2'(c));
            end
        end
    end

    // Read path: data one cycle after the strobe, buffer zero-extended
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdPending <= 1'b0;
            rdFromBuf <= 1'b0;
            regHold <= 16'h0000;
        end else begin
            rdPending <= regRd;
            rdFromBuf <= regAddr[4];
            unique case (regAddr)
                {1'b0, `ADSC_OFF_CTRL1}: regHold <= ctrl1;
                {1'b0, `ADSC_OFF_CTRL2}: regHold <= {conversionIrqFlag, ctrl2[14:0]};
                {1'b0, `ADSC_OFF_CTRL3}: regHold <= ctrl3;
                {1'b0, `ADSC_OFF_INSEL}: regHold <= inputSelect;
                {1'b0, `ADSC_OFF_PINCFG}: regHold <= pinCfg;
                {1'b0, `ADSC_OFF_SCANSEL}: regHold <= scanSelect;
                default: regHold <= 16'h0000;
            endcase
        end
    end

    assign regRdData = !rdPending ? 16'h0000 : rdFromBuf ? {6'h00, ramRdData} : regHold;

    a_abort_stops: assert property (@(posedge clk) disable iff (rst)
        !convOn |=> state == ST_IDLE) else $error("sequencer ran while off");
    a_no_write_off: assert property (@(posedge clk) disable iff (rst)
        !convOn |-> !ramWr) else $error("buffer written while off");
    a_done_group: assert property (@(posedge clk) disable iff (rst)
        groupEnd |=> conversionIrqFlag && ctrl1[`ADSC_CTRL1_DONE]) else $error("flags not set");
    a_ptr_reset: assert property (@(posedge clk) disable iff (rst)
        groupEnd && !ctrl2[`ADSC_CTRL2_SPLIT] |=> wrPtr == 4'h0) else $error("pointer not rewound");
    a_half_swap: assert property (@(posedge clk) disable iff (rst)
        groupEnd && ctrl2[`ADSC_CTRL2_SPLIT] |=> upperHalf != $past(upperHalf)) else $error("half kept");
    a_split_range: assert property (@(posedge clk) disable iff (rst)
        ctrl2[`ADSC_CTRL2_SPLIT] && ramWr |-> wrPtr[3] == upperHalf) else $error("wrote wrong half");
    a_conv_len: assert property (@(posedge clk) disable iff (rst)
        $rose(state == ST_CONVERT) |-> tadCount == 5'h00) else $error("conversion count not cleared");
    a_alt_off: assert property (@(posedge clk) disable iff (rst)
        !ctrl2[`ADSC_CTRL2_ALT] |=> !useSetB) else $error("set B used");
    a_sw_trig: assert property (@(posedge clk) disable iff (rst)
        state == ST_SAMPLE && convOn && trigSel == `ADSC_TRIG_SW && sampleClr |=> state == ST_CONVERT)
        else $error("software trigger missed");
    a_ch_range: assert property (@(posedge clk) disable iff (rst)
        chIdx <= last_channel(numCh) || state == ST_IDLE) else $error("channel out of range");
    a_ptr_step: assert property (@(posedge clk) disable iff (rst)
        ramWr && !groupEnd && !ctrl2[`ADSC_CTRL2_SPLIT] |=> wrPtr == $past(wrPtr) + 4'h1)
        else $error("pointer did not step");
    a_sim_start: assert property (@(posedge clk) disable iff (rst)
        state == ST_NEXT && convOn && ctrl1[`ADSC_CTRL1_SIMSEL] && chIdx != last_channel(numCh) |=> convReq.start)
        else $error("next channel not started");
    c_group: cover property (@(posedge clk) groupEnd);
    c_split: cover property (@(posedge clk) groupEnd && ctrl2[`ADSC_CTRL2_SPLIT]);
    c_four_sim: cover property (@(posedge clk) seqEnd && numCh == 2'h2 && ctrl1[`ADSC_CTRL1_SIMSEL]);
    c_abort: cover property (@(posedge clk) state == ST_CONVERT ##1 !convOn);
endmodule

// File: adsc_core_model.sv
// Behavioural converter core answering conversion requests
`timescale 1ns/100ps
module adsc_core_model
    import adsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input adsc_conv_req_s convReq,
    input wire logic [5:0] divider,
    output logic [9:0] convResult
);
    logic [9:0] held;
    int holdLeft;
    // Result code names input and channel so the bench can trace placement
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held <= 10'h000;
            holdLeft <= 0;
        end else if (convReq.start) begin
            held <= {convReq.sel.posInput, convReq.channel, 4'h9};
            holdLeft <= 14 * (divider + 1) + 2;
        end else if (holdLeft > 0) begin
            holdLeft <= holdLeft - 1;
        end
    end
    // Outside the hold window the core shows junk, never the last value
    assign convResult = (holdLeft > 0) ? held : ~held;
endmodule

// File: tb.sv
// Self-checking bench for the converter sequence control block
`timescale 1ns/100ps
module tb;
    import adsc_pkg::*;
    logic clk, rst, regWr, regRd, conversionIrqFlag;
    logic [4:0] regAddr;
    logic [15:0] regWrData, regRdData, pinAnalog, rd;
    logic [5:0] extTrig;
    logic [9:0] convResult;
    logic [3:0] holdSample;
    adsc_conv_req_s convReq;
    int n_fail = 0;
    int tests_run = 0;

    adsc_seq_ctrl adsc_seq_ctrl_i (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .extTrig(extTrig), .convResult(convResult),
        .convReq(convReq), .holdSample(holdSample), .pinAnalog(pinAnalog),
        .conversionIrqFlag(conversionIrqFlag));
    adsc_core_model adsc_core_model_i (.clk(clk), .rst(rst), .convReq(convReq), .divider(6'h01),
        .convResult(convResult));

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrReg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rdReg(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask

    task automatic chkBuf(input int k, input logic [15:0] exp);
        logic [15:0] v;
        rdReg(5'(16 + k), v);
        check("buffer word", v, exp);
    endtask

    task automatic waitIrq();
        int i;
        for (i = 0; i < 600 && conversionIrqFlag !== 1'b1; i++) @(posedge clk);
        check("irq raised", {15'h0, conversionIrqFlag}, 16'h0001);
    endtask

    task automatic testReset();
        int a;
        check("reset request", 16'(convReq), 16'h0000);
        check("reset outputs", {holdSample, 11'h0, conversionIrqFlag}, 16'h0000);
        for (a = 0; a < 7; a++) begin
            rdReg(a[4:0], rd);
            check("reset register", rd, 16'h0000);
        end
        wrReg(5'h04, 16'hA5C3);
        @(posedge clk);
        #1;
        check("pin config out", pinAnalog, 16'hA5C3);
        rdReg(5'h04, rd);
        check("pin config read", rd, 16'hA5C3);
        $display("finished reset test");
    endtask

    task automatic testAltAuto();
        wrReg(5'h00, 16'h0000);
        wrReg(5'h01, 16'h8005);
        wrReg(5'h02, 16'h0401);
        wrReg(5'h03, 16'h0C03);
        wrReg(5'h00, 16'h80E6);
        waitIrq();
        rdReg(5'h00, rd);
        wrReg(5'h00, 16'h0000);
        check("done flag", rd & 16'h0001, 16'h0001);
        chkBuf(0, 16'h00C9);
        chkBuf(1, 16'h0309);
        wrReg(5'h10, 16'h0155);
        chkBuf(0, 16'h00C9);
        $display("finished alternate test");
    endtask

    task automatic testScanSplit();
        wrReg(5'h01, 16'hA406);
        wrReg(5'h05, 16'h0224);
        wrReg(5'h00, 16'h80E6);
        waitIrq();
        check("reference select", {14'h0, convReq.vref}, 16'h0001);
        // Same field values, only the flag is cleared
        wrReg(5'h01, 16'hA406);
        chkBuf(0, 16'h0089);
        chkBuf(1, 16'h0149);
        waitIrq();
        wrReg(5'h00, 16'h0000);
        chkBuf(8, 16'h0089);
        chkBuf(9, 16'h0149);
        chkBuf(0, 16'h0089);
        $display("finished scan test");
    endtask

    task automatic testSimultaneous();
        int k;
        wrReg(5'h01, 16'h8200);
        wrReg(5'h00, 16'h8008);
        wrReg(5'h00, 16'h800A);
        repeat (3) @(posedge clk);
        check("hold all", {12'h0, holdSample}, 16'h000F);
        wrReg(5'h00, 16'h8008);
        waitIrq();
        for (k = 0; k < 4; k++) begin
            rdReg(5'(16 + k), rd);
            check("channel order", rd & 16'h003F, {10'h0, k[1:0], 4'h9});
        end
        chkBuf(0, 16'h00C9);
        $display("finished simultaneous test");
    endtask

    task automatic testAbort();
        wrReg(5'h00, 16'h0000);
        wrReg(5'h01, 16'h8000);
        wrReg(5'h03, 16'h0C07);
        wrReg(5'h00, 16'h8000);
        wrReg(5'h00, 16'h8002);
        repeat (3) @(posedge clk);
        check("hold ch0", {12'h0, holdSample}, 16'h0001);
        wrReg(5'h00, 16'h8000);
        repeat (6) @(posedge clk);
        wrReg(5'h00, 16'h0000);
        repeat (80) @(posedge clk);
        check("abort irq", {15'h0, conversionIrqFlag}, 16'h0000);
        chkBuf(0, 16'h00C9);
        $display("finished abort test");
    endtask

    task automatic testExtTrig();
        int n;
        for (n = 1; n < 7; n++) begin
            wrReg(5'h00, 16'h0000);
            wrReg(5'h01, 16'h8000);
            wrReg(5'h00, {8'h80, n[2:0], 5'h00});
            wrReg(5'h00, {8'h80, n[2:0], 5'h02});
            repeat (4) @(posedge clk);
            extTrig <= 6'(1 << (n - 1));
            waitIrq();
            extTrig <= 6'h00;
            chkBuf(0, 16'h01C9);
        end
        wrReg(5'h00, 16'h0000);
        $display("finished trigger test");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 5'h00;
        regWrData = 16'h0000;
        extTrig = 6'h00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        testReset();
        testAltAuto();
        testScanSplit();
        testSimultaneous();
        testAbort();
        testExtTrig();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
endmodule
